// *** core/atc_trigger_ctrl.sv ***
/*
  Acquisition trigger controller: hardware analog and digital start
  triggers, software trigger and stop commands, four pre/post trigger modes,
  circular buffer write addressing, Avalon-MM register slave and interrupt.
  Assumes an external comparator against dac_level, a scan sequencer that
  pulses reading_valid per stored reading, and a buffer of 2**20 words.
*/
`timescale 1ns/1ps
`include "atc_regs.svh"

// Summary of operation
// RULE1: Threshold DAC plus comparator, trigger within 1 us
// RULE2: Host puts trigger channel first in scan
// RULE3: Programmable threshold, edge polarity and hysteresis
// RULE4: Fire only on comparator change after arming
// RULE5: Digital input level or edge, under 1 us
// RULE6: Host checks analog readings for soft trigger
// RULE7: Host compares masked digital pattern
// RULE8: Host fires on counter threshold or range
// RULE9: Late soft trigger starts at causing reading
// RULE10: Soft conditions may also stop acquisition
// RULE11: Pre-trigger modes need a software trigger
// RULE12: No pre-trigger, stop on stop event
// RULE13: Keep programmed pre-trigger readings, stop on event
// RULE14: No pre-trigger, run until host halt
// RULE15: Keep pre-trigger readings, run until halt
// RULE16: Waiting pre-trigger writes buffer circularly
module atc_trigger_ctrl
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [`ATC_AVS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic comp_in,
  input wire logic digital_trigger_input,
  output logic [15:0] dac_level,
  input wire logic reading_valid,
  output logic buf_wr_en,
  output logic [`ATC_ADDR_W-1:0] buf_wr_addr,
  output logic scan_gate,
  output logic seq_reset,
  output logic trig_pulse,
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  atc_pkg::atc_state_s r_reg; // Registered state
  atc_pkg::atc_state_s r_next; // Next state
  logic pre_mode; // Pre-trigger data wanted
  logic inf_mode; // Only a halt ends the run
  atc_pkg::atc_src_e src; // Start source
  logic soft_src; // Software start selected
  logic ana_act; // Comparator on the trigger side
  logic wr_acc; // Write completes this edge
  logic cmd_arm; // Arm command
  logic cmd_halt; // Halt command
  logic cmd_stop; // Stop event command
  logic sw_fire; // Software trigger write
  logic hw_fire; // Hardware trigger seen
  logic [`ATC_ADDR_W-1:0] pre_used; // Pre-trigger depth actually held

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Saturating 16-bit step, used for both edges of the hysteresis band
  function automatic logic [15:0] sat_step(input logic [15:0] a, input logic [15:0] b,
                                           input logic down);
    logic [16:0] s;
    s = 17'h0_0000;
    if (down)
    begin
      s = {1'b0, a} - {1'b0, b};
      sat_step = s[16] ? 16'h0000 : s[15:0];
    end
    else
    begin
      s = {1'b0, a} + {1'b0, b};
      sat_step = s[16] ? 16'hFFFF : s[15:0];
    end
  endfunction

  // ****************************************************************
  // Decoded configuration and commands
  // ****************************************************************
  assign pre_mode = r_reg.cfg[`ATC_CFG_MODE];
  assign inf_mode = r_reg.cfg[`ATC_CFG_MODE+1];
  assign src = atc_pkg::atc_src_e'(r_reg.cfg[`ATC_CFG_SRC+1:`ATC_CFG_SRC]);
  assign soft_src = src[1];
  // Trigger side of the comparator depends on the chosen edge
  assign ana_act = r_reg.comp_f ^ r_reg.cfg[`ATC_CFG_AFALL]; // [RULE3]
  assign wr_acc = avs_write & r_reg.ack;
  assign cmd_arm = wr_acc & (avs_address == `ATC_OFS_CMD) & avs_writedata[`ATC_CMD_ARM];
  assign cmd_halt = wr_acc & (avs_address == `ATC_OFS_CMD) & avs_writedata[`ATC_CMD_HALT];
  // Stop events are judged by the host and delivered as one command
  assign cmd_stop = wr_acc & (avs_address == `ATC_OFS_CMD) & avs_writedata[`ATC_CMD_STOP]; // [RULE10]
  // Software start only where the mode or the source calls for it
  assign sw_fire = wr_acc & (avs_address == `ATC_OFS_SWTRIG) & (pre_mode | soft_src); // [RULE11]

  // Hardware starts are refused in pre-trigger modes
  always_comb
  begin
    hw_fire = 1'b0;
    if (!pre_mode) // [RULE11]
    begin
      unique case (src)
        atc_pkg::ATC_SRC_ANALOG: hw_fire = r_reg.seen_idle & ana_act; // [RULE1] [RULE4]
        atc_pkg::ATC_SRC_DIGITAL:
        begin
          if (r_reg.cfg[`ATC_CFG_DEDGE])
            hw_fire = (r_reg.dig_f != r_reg.dig_prev) &
                      (r_reg.dig_f == r_reg.cfg[`ATC_CFG_DPOL]); // [RULE5]
          else
            hw_fire = (r_reg.dig_f == r_reg.cfg[`ATC_CFG_DPOL]); // [RULE5]
        end
        atc_pkg::ATC_SRC_SOFT, atc_pkg::ATC_SRC_SOFT_ALT: hw_fire = 1'b0;
      endcase
    end
  end

  // Fewer readings than asked may exist if the trigger came early
  assign pre_used = (r_reg.pre_avail < r_reg.pre) ? r_reg.pre_avail : r_reg.pre; // [RULE13]

  // ****************************************************************
  // Next state
  // ****************************************************************
  // One process computes the whole next state record
  always_comb
  begin
    r_next = r_reg;
    r_next.seq_rst = 1'b0;
    r_next.trig_pulse = 1'b0;
    r_next.ack = 1'b0;

    // Pin synchronisers: a level counts once stages two and three agree
    r_next.comp_sync = {r_reg.comp_sync[1:0], comp_in};
    if (r_reg.comp_sync[1] == r_reg.comp_sync[2])
      r_next.comp_f = r_reg.comp_sync[2];
    r_next.dig_sync = {r_reg.dig_sync[1:0], digital_trigger_input};
    if (r_reg.dig_sync[1] == r_reg.dig_sync[2])
      r_next.dig_f = r_reg.dig_sync[2];
    r_next.dig_prev = r_reg.dig_f;

    // Bus: one wait cycle, read data captured on the first edge
    if ((avs_read | avs_write) & ~r_reg.ack)
    begin
      r_next.ack = 1'b1;
      r_next.rdata = 32'h0000_0000;
      unique case (avs_address)
        `ATC_OFS_CFG: r_next.rdata = r_reg.cfg;
        `ATC_OFS_LEVEL: r_next.rdata = r_reg.level;
        `ATC_OFS_PRE: r_next.rdata = {12'h000, r_reg.pre};
        `ATC_OFS_STATUS: r_next.rdata = {27'h000_0000, r_reg.dig_f, r_reg.comp_f,
                                         r_reg.seen_idle, r_reg.st};
        `ATC_OFS_TRIGADDR: r_next.rdata = {12'h000, r_reg.trig_addr};
        `ATC_OFS_START: r_next.rdata = {12'h000, r_reg.start_addr};
        `ATC_OFS_WRPTR: r_next.rdata = {12'h000, r_reg.wr_ptr};
        `ATC_OFS_IRQST: r_next.rdata = {30'h0000_0000, r_reg.irq_st};
        `ATC_OFS_IRQMSK: r_next.rdata = {30'h0000_0000, r_reg.irq_msk};
        default: r_next.rdata = 32'h0000_0000; // Unmapped and write-only read zero
      endcase
    end

    // Configuration writes
    if (wr_acc)
    begin
      unique case (avs_address)
        `ATC_OFS_CFG: r_next.cfg = avs_writedata;
        `ATC_OFS_LEVEL: r_next.level = avs_writedata; // [RULE3]
        `ATC_OFS_PRE: r_next.pre = avs_writedata[`ATC_ADDR_W-1:0]; // [RULE13]
        `ATC_OFS_IRQMSK: r_next.irq_msk = avs_writedata[1:0];
        default: ;
      endcase
    end

    // Read of the status clears only the bits it returned; a new set wins
    if (avs_read & r_reg.ack & (avs_address == `ATC_OFS_IRQST))
      r_next.irq_st = r_reg.irq_st & ~r_reg.rdata[1:0];

    // Buffer addressing wraps, so waiting overwrites the oldest entry
    if (reading_valid & scan_gate)
    begin
      r_next.wr_ptr = r_reg.wr_ptr + `ATC_ADDR_W'(1); // [RULE16]
      if ((r_reg.st == atc_pkg::ATC_ARMED) && (r_reg.pre_avail != r_reg.pre))
        r_next.pre_avail = r_reg.pre_avail + `ATC_ADDR_W'(1);
    end

    // Hysteresis band: before qualifying, the reference is moved away
    if ((r_reg.st == atc_pkg::ATC_ARMED) && !r_reg.seen_idle)
      r_next.dac = sat_step(r_reg.level[`ATC_LVL_THR+:16], r_reg.level[`ATC_LVL_HYS+:16],
                            ~r_reg.cfg[`ATC_CFG_AFALL]); // [RULE3]
    else
      r_next.dac = r_reg.level[`ATC_LVL_THR+:16]; // [RULE1]

    // Controller sequence
    unique case (r_reg.st)
      atc_pkg::ATC_IDLE, atc_pkg::ATC_DONE:
      begin
        if (cmd_arm)
        begin
          // New scan: restart sequencer and buffer, forget the comparator
          r_next.st = atc_pkg::ATC_ARMED;
          r_next.wr_ptr = `ATC_ADDR_W'(0);
          r_next.pre_avail = `ATC_ADDR_W'(0);
          r_next.seen_idle = 1'b0; // [RULE4]
          r_next.seq_rst = 1'b1;
        end
      end
      atc_pkg::ATC_ARMED:
      begin
        // A comparator already tripped must first return across the band
        if (!ana_act)
          r_next.seen_idle = 1'b1; // [RULE4]
        if (cmd_halt)
          r_next.st = atc_pkg::ATC_IDLE;
        else if (hw_fire)
        begin
          r_next.st = atc_pkg::ATC_ACQ; // [RULE12] [RULE14]
          r_next.trig_addr = r_reg.wr_ptr;
          r_next.start_addr = r_reg.wr_ptr;
          r_next.trig_pulse = 1'b1;
          r_next.irq_st[`ATC_IRQ_TRIG] = 1'b1;
        end
        else if (sw_fire)
        begin
          // Host names the reading that caused the trigger
          r_next.st = atc_pkg::ATC_ACQ;
          r_next.trig_addr = avs_writedata[`ATC_ADDR_W-1:0]; // [RULE9]
          r_next.start_addr = avs_writedata[`ATC_ADDR_W-1:0] - pre_used; // [RULE13] [RULE15]
          r_next.trig_pulse = 1'b1;
          r_next.irq_st[`ATC_IRQ_TRIG] = 1'b1;
        end
      end
      atc_pkg::ATC_ACQ:
      begin
        // Infinite modes ignore stop events and end only on halt
        if (cmd_halt | (cmd_stop & ~inf_mode)) // [RULE12] [RULE13] [RULE14] [RULE15]
        begin
          r_next.st = atc_pkg::ATC_DONE;
          r_next.irq_st[`ATC_IRQ_STOP] = 1'b1;
        end
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // All state is reset to constants only
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r_reg <= '0;
      r_reg.st <= atc_pkg::ATC_IDLE;
      r_reg.cfg <= `ATC_RST_CFG;
      r_reg.level <= `ATC_RST_LEVEL;
      r_reg.pre <= `ATC_RST_PRE;
      r_reg.irq_msk <= `ATC_RST_MASK;
    end
    else
      r_reg <= r_next;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Readings are stored while acquiring, and while waiting if the host
  // may need to look back; otherwise the sequencer is held off
  assign scan_gate = (r_reg.st == atc_pkg::ATC_ACQ) ||
                     ((r_reg.st == atc_pkg::ATC_ARMED) && (pre_mode | soft_src)); // [RULE16]
  assign buf_wr_en = reading_valid & scan_gate;
  assign buf_wr_addr = r_reg.wr_ptr;
  assign avs_waitrequest = (avs_read | avs_write) & ~r_reg.ack;
  assign avs_readdata = r_reg.rdata;
  assign dac_level = r_reg.dac;
  assign seq_reset = r_reg.seq_rst;
  assign trig_pulse = r_reg.trig_pulse;
  assign irq = |(r_reg.irq_st & r_reg.irq_msk);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  bus_ack_a: assert property (r_reg.ack |=> !r_reg.ack)
    else $error("waitrequest low for more than one cycle");
  ana_arm_a: assert property ((r_reg.st == atc_pkg::ATC_ARMED && src == atc_pkg::ATC_SRC_ANALOG
    && !pre_mode && !r_reg.seen_idle) |=> r_reg.st != atc_pkg::ATC_ACQ) // [RULE4]
    else $error("analog trigger fired without a change after arming");
  ana_fire_a: assert property ((r_reg.st == atc_pkg::ATC_ARMED && src == atc_pkg::ATC_SRC_ANALOG
    && !pre_mode && r_reg.seen_idle && ana_act && !cmd_halt)
    |=> r_reg.st == atc_pkg::ATC_ACQ && r_reg.trig_pulse) // [RULE1]
    else $error("qualified comparator crossing did not trigger");
  dac_thr_a: assert property ((r_reg.st == atc_pkg::ATC_ACQ && $past(r_reg.st) ==
    atc_pkg::ATC_ACQ && $stable(r_reg.level)) |-> r_reg.dac == r_reg.level[15:0]) // [RULE3]
    else $error("reference not at threshold during acquisition");
  dig_level_a: assert property ((r_reg.st == atc_pkg::ATC_ARMED && src ==
    atc_pkg::ATC_SRC_DIGITAL && !pre_mode && !r_reg.cfg[`ATC_CFG_DEDGE] &&
    r_reg.dig_f == r_reg.cfg[`ATC_CFG_DPOL] && !cmd_halt)
    |=> r_reg.st == atc_pkg::ATC_ACQ) // [RULE5]
    else $error("digital level trigger missed");
  pre_hw_a: assert property ((r_reg.st == atc_pkg::ATC_ARMED && pre_mode && !sw_fire)
    |=> r_reg.st != atc_pkg::ATC_ACQ) // [RULE11]
    else $error("pre-trigger mode started without software trigger");
  sw_start_a: assert property ((r_reg.st == atc_pkg::ATC_ARMED && sw_fire && !hw_fire
    && !cmd_halt) |=> r_reg.trig_addr == $past(avs_writedata[19:0])) // [RULE9]
    else $error("software trigger position not taken");
  pre_keep_a: assert property ((r_reg.st == atc_pkg::ATC_ARMED && sw_fire && pre_mode &&
    r_reg.pre_avail == r_reg.pre && !cmd_halt) |=> r_reg.start_addr ==
    `ATC_ADDR_W'(r_reg.trig_addr - $past(r_reg.pre))) // [RULE13]
    else $error("start address does not hold pre-trigger readings");
  stop_evt_a: assert property ((r_reg.st == atc_pkg::ATC_ACQ && !inf_mode && cmd_stop)
    |=> r_reg.st == atc_pkg::ATC_DONE) // [RULE12]
    else $error("stop event did not end acquisition");
  inf_run_a: assert property ((r_reg.st == atc_pkg::ATC_ACQ && inf_mode && !cmd_halt)
    |=> r_reg.st == atc_pkg::ATC_ACQ) // [RULE14]
    else $error("infinite acquisition ended without halt");
  halt_end_a: assert property ((r_reg.st == atc_pkg::ATC_ACQ && cmd_halt)
    |=> r_reg.st == atc_pkg::ATC_DONE && r_reg.irq_st[`ATC_IRQ_STOP]) // [RULE15]
    else $error("halt did not end acquisition");
  circ_wr_a: assert property ((r_reg.st == atc_pkg::ATC_ARMED && pre_mode && reading_valid
    && !cmd_halt) |=> r_reg.wr_ptr == `ATC_ADDR_W'($past(r_reg.wr_ptr) + 1)) // [RULE16]
    else $error("buffer pointer did not advance while waiting");

  ana_trig_c: cover property (r_reg.st == atc_pkg::ATC_ARMED && src ==
    atc_pkg::ATC_SRC_ANALOG ##1 r_reg.trig_pulse);
  sw_pre_c: cover property (sw_fire && pre_mode && r_reg.pre_avail == r_reg.pre);
  halt_c: cover property (r_reg.st == atc_pkg::ATC_ACQ && inf_mode && cmd_halt);
  irq_c: cover property (irq ##1 !irq);

endmodule

// *** core/atc_regs.svh ***
/*
  Register offsets, field positions, reset values and timing counts of the
  acquisition trigger controller.
  Assumes a 200 MHz core clock and byte addresses on the Avalon-MM slave.
*/
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define ATC_ADDR_W 20
`define ATC_AVS_AW 6

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ATC_OFS_CMD 6'h00
`define ATC_OFS_CFG 6'h04
`define ATC_OFS_LEVEL 6'h08
`define ATC_OFS_PRE 6'h0C
`define ATC_OFS_SWTRIG 6'h10
`define ATC_OFS_STATUS 6'h14
`define ATC_OFS_TRIGADDR 6'h18
`define ATC_OFS_START 6'h1C
`define ATC_OFS_WRPTR 6'h20
`define ATC_OFS_IRQST 6'h24
`define ATC_OFS_IRQMSK 6'h28

// ****************************************************************
// Field positions
// ****************************************************************
`define ATC_CMD_ARM 0
`define ATC_CMD_HALT 1
`define ATC_CMD_STOP 2
`define ATC_CFG_MODE 0
`define ATC_CFG_SRC 2
`define ATC_CFG_AFALL 4
`define ATC_CFG_DEDGE 5
`define ATC_CFG_DPOL 6
`define ATC_LVL_THR 0
`define ATC_LVL_HYS 16
`define ATC_IRQ_TRIG 0
`define ATC_IRQ_STOP 1

// ****************************************************************
// Reset values
// ****************************************************************
`define ATC_RST_CFG 32'h0000_0000
`define ATC_RST_LEVEL 32'h0000_0000
`define ATC_RST_PRE 20'h0_0000
`define ATC_RST_MASK 2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define ATC_CLK_PS 5000
`define ATC_TRIG_LAT_NS 1000
`define ATC_TRIG_LAT_CYC ((`ATC_TRIG_LAT_NS * 1000) / `ATC_CLK_PS)

`endif

// *** core/atc_pkg.sv ***
/*
  Types of the acquisition trigger controller: states, sources and
  the packed state record.
  Assumes atc_regs.svh is on the include path.
*/
`include "atc_regs.svh"

package atc_pkg;

  // Controller states, Gray coded along idle, armed, acquire, done
  typedef enum logic [1:0]
  {
    ATC_IDLE = 2'b00,
    ATC_ARMED = 2'b01,
    ATC_ACQ = 2'b11,
    ATC_DONE = 2'b10
  } atc_state_e;

  // Start trigger source; code 3 behaves as software
  typedef enum logic [1:0]
  {
    ATC_SRC_ANALOG = 2'h0,
    ATC_SRC_DIGITAL = 2'h1,
    ATC_SRC_SOFT = 2'h2,
    ATC_SRC_SOFT_ALT = 2'h3
  } atc_src_e;

  // Whole state of the controller
  typedef struct packed
  {
    atc_state_e st;
    logic [2:0] comp_sync;
    logic comp_f;
    logic [2:0] dig_sync;
    logic dig_f;
    logic dig_prev;
    logic seen_idle;
    logic [31:0] cfg;
    logic [31:0] level;
    logic [`ATC_ADDR_W-1:0] pre;
    logic [`ATC_ADDR_W-1:0] wr_ptr;
    logic [`ATC_ADDR_W-1:0] trig_addr;
    logic [`ATC_ADDR_W-1:0] start_addr;
    logic [`ATC_ADDR_W-1:0] pre_avail;
    logic [1:0] irq_st;
    logic [1:0] irq_msk;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] dac;
    logic seq_rst;
    logic trig_pulse;
  } atc_state_s;

endpackage

// *** dv/atc_front_model.sv ***
/*
  Front-end model: the level comparator against the reference DAC and the
  scan sequencer that pulses one reading every fourth slot.
  Assumes it shares core_clk and rstn with the trigger controller.
*/
`timescale 1ns/1ps
module atc_front_model
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [15:0] dac_level,
  input wire logic [15:0] level_in,
  input wire logic run,
  output logic comp_in,
  output logic reading_valid
);
  logic [1:0] phase; // Slot within a four-reading scan

  // Comparator output and reading pulses; slot 0 is the trigger channel
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      comp_in <= 1'b0;
      phase <= 2'h0;
      reading_valid <= 1'b0;
    end
    else
    begin
      comp_in <= level_in > dac_level;
      phase <= run ? phase + 2'h1 : 2'h0;
      reading_valid <= run && phase == 2'h3;
    end
  end
endmodule

// *** dv/acquisition_trigger_control_test.sv ***
/*
  Self-checking bench of the trigger controller: register bus, analog,
  digital and software triggers, the four modes and the interrupt.
  Assumes atc_regs.svh on the include path and the front-end model.
*/
`timescale 1ns/1ps
`include "atc_regs.svh"
module acquisition_trigger_control_test;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [`ATC_AVS_AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic comp_in;
  logic digital_trigger_input = 1'b0;
  logic [15:0] dac_level;
  logic reading_valid;
  logic buf_wr_en;
  logic [`ATC_ADDR_W-1:0] buf_wr_addr;
  logic scan_gate;
  logic seq_reset;
  logic trig_pulse;
  logic irq;
  logic [15:0] level_in = 16'h0000; // Analog input seen by the comparator
  logic run = 1'b0; // Sequencer scanning
  int n_fail = 0;
  int checked = 0;
  int n_rst = 0; // Count of scan restarts seen
  int n_wr = 0; // Count of buffer write strobes seen
  logic [31:0] q;
  logic seen;

  atc_trigger_ctrl DUT (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .comp_in(comp_in),
    .digital_trigger_input(digital_trigger_input), .dac_level(dac_level),
    .reading_valid(reading_valid), .buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr),
    .scan_gate(scan_gate), .seq_reset(seq_reset), .trig_pulse(trig_pulse), .irq(irq));
  atc_front_model FRONT (.core_clk(core_clk), .rstn(rstn), .dac_level(dac_level),
    .level_in(level_in), .run(run), .comp_in(comp_in), .reading_valid(reading_valid));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Clock at 200 MHz
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  // Restart and write pulses are counted, since they last a single cycle
  always @(posedge core_clk)
  begin
    if (seq_reset === 1'b1) n_rst++;
    if (buf_wr_en === 1'b1) n_wr++;
  end

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One Avalon access; the request stands until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) chk(1'b0, 1'b1, "bus answer");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Watch trig_pulse for a bounded number of cycles
  task automatic wait_trig(input int limit);
    seen = 1'b0;
    repeat (limit)
    begin
      @(posedge core_clk);
      if (trig_pulse === 1'b1) seen = 1'b1;
    end
  endtask

  task automatic st_is(input logic [1:0] exp, input string msg);
    bus(1'b0, `ATC_OFS_STATUS, 0);
    chk(q[1:0], exp, msg);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, an unmapped place and idle outputs
  task automatic t_reset();
    bus(1'b0, `ATC_OFS_CFG, 0);
    chk(q, `ATC_RST_CFG, "cfg reset");
    bus(1'b0, `ATC_OFS_LEVEL, 0);
    chk(q, `ATC_RST_LEVEL, "level reset");
    bus(1'b0, `ATC_OFS_IRQMSK, 0);
    chk(q, 32'h0000_0000, "mask reset");
    bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
    bus(1'b0, 6'h3C, 0);
    chk(q, 32'h0000_0000, "unmapped read");
    chk(scan_gate, 1'b0, "gate idle");
  endtask

  // Hardware analog trigger, rising edge, hysteresis, stop event and irq
  task automatic t_analog();
    bus(1'b1, `ATC_OFS_LEVEL, 32'h0100_8000);
    bus(1'b1, `ATC_OFS_CFG, 32'h0000_0000);
    bus(1'b1, `ATC_OFS_IRQMSK, 32'h0000_0002);
    level_in <= 16'h9000; // Already past the threshold before arming
    repeat (10) @(posedge core_clk); // Let the synchroniser settle first
    n_rst = 0;
    bus(1'b1, `ATC_OFS_CMD, 32'h0000_0001);
    wait_trig(60);
    chk(seen, 1'b0, "tripped before arm");
    chk(n_rst, 1, "scan restart");
    chk(dac_level, 16'h7F00, "reference minus hysteresis");
    level_in <= 16'h7F80; // Inside the hysteresis band only
    repeat (10) @(posedge core_clk);
    level_in <= 16'h9000;
    wait_trig(60);
    chk(seen, 1'b0, "band crossing");
    level_in <= 16'h7000;
    repeat (10) @(posedge core_clk);
    level_in <= 16'h9000;
    wait_trig(`ATC_TRIG_LAT_CYC);
    chk(seen, 1'b1, "analog trigger latency");
    chk(dac_level, 16'h8000, "reference at threshold");
    chk(irq, 1'b0, "masked trigger bit");
    run <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk(scan_gate, 1'b1, "acquiring after trigger");
    chk(buf_wr_addr > 20'h0, 1'b1, "readings stored");
    bus(1'b1, `ATC_OFS_CMD, 32'h0000_0004);
    st_is(atc_pkg::ATC_DONE, "stop event ends");
    chk(scan_gate, 1'b0, "gate after stop");
    chk(irq, 1'b1, "stop interrupt");
    bus(1'b0, `ATC_OFS_IRQST, 0);
    chk(q[1:0], 2'h3, "irq status");
    @(posedge core_clk); // The clear lands at the edge that ends the read
    chk(irq, 1'b0, "irq cleared by read");
    run <= 1'b0;
  endtask

  // Hardware analog trigger on the falling edge, band above the threshold
  task automatic t_fall();
    bus(1'b1, `ATC_OFS_CFG, 32'h0000_0010);
    level_in <= 16'h7000; // Already below the threshold before arming
    repeat (10) @(posedge core_clk);
    bus(1'b1, `ATC_OFS_CMD, 32'h0000_0001);
    wait_trig(30);
    chk(seen, 1'b0, "falling tripped before arm");
    chk(dac_level, 16'h8100, "reference plus hysteresis");
    level_in <= 16'h9000;
    repeat (10) @(posedge core_clk);
    level_in <= 16'h7000;
    wait_trig(`ATC_TRIG_LAT_CYC);
    chk(seen, 1'b1, "falling analog trigger");
    bus(1'b1, `ATC_OFS_CMD, 32'h0000_0002);
  endtask

  // Digital trigger, high level then falling edge, stop versus halt
  task automatic t_digital();
    bus(1'b1, `ATC_OFS_CFG, 32'h0000_0046);
    bus(1'b1, `ATC_OFS_CMD, 32'h0000_0001);
    wait_trig(30);
    chk(seen, 1'b0, "level not met");
    digital_trigger_input <= 1'b1;
    wait_trig(`ATC_TRIG_LAT_CYC);
    chk(seen, 1'b1, "high level trigger");
    bus(1'b1, `ATC_OFS_CMD, 32'h0000_0004);
    st_is(atc_pkg::ATC_ACQ, "stop ignored when infinite");
    bus(1'b1, `ATC_OFS_CMD, 32'h0000_0002);
    st_is(atc_pkg::ATC_DONE, "halt ends");
    bus(1'b1, `ATC_OFS_CFG, 32'h0000_0026);
    digital_trigger_input <= 1'b0; // Already at the edge's target level
    repeat (10) @(posedge core_clk);
    bus(1'b1, `ATC_OFS_CMD, 32'h0000_0001);
    wait_trig(30);
    chk(seen, 1'b0, "edge mode ignores level");
    digital_trigger_input <= 1'b1;
    repeat (10) @(posedge core_clk);
    digital_trigger_input <= 1'b0;
    wait_trig(`ATC_TRIG_LAT_CYC);
    chk(seen, 1'b1, "falling edge trigger");
    bus(1'b1, `ATC_OFS_CMD, 32'h0000_0002);
  endtask

  // Software trigger with pre-trigger, stop event mode and infinite mode
  task automatic t_soft();
    for (int m = 1; m <= 3; m += 2)
    begin
      bus(1'b1, `ATC_OFS_CFG, m | (m == 3 ? 12 : 8));
      bus(1'b1, `ATC_OFS_PRE, 32'h0000_0004);
      n_wr = 0;
      bus(1'b1, `ATC_OFS_CMD, 32'h0000_0001);
      run <= 1'b1;
      repeat (80) @(posedge core_clk);
      chk(buf_wr_addr > 20'h4, 1'b1, "stored while armed");
      bus(1'b1, `ATC_OFS_SWTRIG, 32'h0000_0008);
      bus(1'b0, `ATC_OFS_TRIGADDR, 0);
      chk(q[19:0], 20'h0_0008, "causing reading");
      bus(1'b0, `ATC_OFS_START, 0);
      chk(q[19:0], 20'h0_0004, "pre-trigger kept");
      bus(1'b1, `ATC_OFS_CMD, 32'h0000_0004);
      st_is(m == 1 ? atc_pkg::ATC_DONE : atc_pkg::ATC_ACQ, "stop by mode");
      if (m == 3) bus(1'b1, `ATC_OFS_CMD, 32'h0000_0002);
      st_is(atc_pkg::ATC_DONE, "acquisition ended");
      bus(1'b0, `ATC_OFS_WRPTR, 0);
      chk(q, n_wr, "write strobes");
      run <= 1'b0;
    end
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_analog();
    t_fall();
    t_digital();
    t_soft();
    close_out();
  end

  // A hang counts as a mismatch; the whole run needs well under this
  initial
  begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule
